// ==== verilog/adcsp_pkg.sv ====
// Purpose: Constants for the converter serial audio output port.
// Assumes: Block clock is the converter master clock.
// Notes: Register indices are word indices on the plain register port.
//
// What this block does
// - Slave mode measures master-to-frame clock ratio.
// - Ratio error over 32 freezes data output.
// - Ratios 256x, 384x, 512x and 768x accepted.
// - Ratio field divides master clock in master.
// - Oversample bit selects 64x instead of 128x.
// - Master non-DSP bit clock is quarter rate.
// - Master DSP bit clock equals master clock.
// - Input powerdown ties selector inputs to midrail.
// - Converter powerdown stops converter and gain.
// - Global powerdown overrides all; bits reset zero.
// - Role select bit, slave default, data output.
// - Slave samples frame rising, data on falling.
// - Master drives clocks, data on falling edges.
// - MSB first, 16/20/24/32 bit words.
// - Left justified MSB at frame clock edge.
// - Right justified LSB just before frame edge.
// - I2S MSB one bit after frame edge.
// - DSP frame sync marks first word MSB.
// - DSP MSB on first or second edge.
// - DSP right word follows left, gaps after.
// - Format field codes, I2S at reset.
// - Word length codes, 24 bits at reset.
// - Outside DSP, polarity bit inverts expected frame clock.
// - 32 bits in right justified becomes 24.
package adcsp_pkg;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PWR = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_WL_LSB = 2;
    localparam int CTRL_POL_BIT = 4;
    localparam int CTRL_BINV_BIT = 5;
    localparam int CTRL_MS_BIT = 6;
    localparam int CTRL_RATE_LSB = 7;
    localparam int CTRL_OSR_BIT = 10;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_010A;
    localparam int PWR_INPUT_BIT = 0;
    localparam int PWR_CONV_BIT = 1;
    localparam int PWR_GLOBAL_BIT = 2;
    localparam logic [31:0] PWR_MASK = 32'h0000_0007;
    localparam logic [31:0] PWR_RESET = 32'h0000_0000;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_DET_LSB = 2;
    // ************************************************
    // Field encodings
    // ************************************************
    localparam logic [1:0] FMT_RJ = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_20 = 2'h1;
    localparam logic [1:0] WL_24 = 2'h2;
    localparam logic [1:0] WL_32 = 2'h3;
    localparam logic [2:0] RATE_256 = 3'h2;
    localparam logic [2:0] RATE_384 = 3'h3;
    localparam logic [2:0] RATE_512 = 3'h4;
    localparam logic [2:0] RATE_768 = 3'h5;
    localparam logic [9:0] RATIO_256 = 10'h100;
    localparam logic [9:0] RATIO_384 = 10'h180;
    localparam logic [9:0] RATIO_512 = 10'h200;
    localparam logic [9:0] RATIO_768 = 10'h300;
    localparam logic [9:0] RATIO_TOL = 10'h020;
endpackage : adcsp_pkg

// ==== verilog/adcsp_port.sv ====
// Purpose: Serial audio output port with clock ratio detection.
// Assumes: sys_clk_in is the master clock; pins synchronous to it.
// Notes: Bit clock pin in master DSP mode is the master clock itself.
`timescale 1ns/10ps
`default_nettype none
module adcsp_port
    import adcsp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [31:0] left_sample_in,
    input wire logic [31:0] right_sample_in,
    output logic sample_take_out,
    input wire logic frame_clock_in,
    output logic frame_clock_out,
    output logic frame_clock_oe_n_out,
    input wire logic serial_bit_clock_in,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe_n_out,
    output logic converter_data_out,
    output logic oversample_sel_out,
    output logic input_mux_powerdown_out,
    output logic input_to_midrail_out,
    output logic converter_powerdown_out,
    output logic reference_powerdown_out
);
    // ************************************************
    // Decoding helpers
    // ************************************************
    function automatic logic [5:0] word_bits(input logic [1:0] fmt,
                                             input logic [1:0] wl);
        logic [5:0] n;
        case (wl)
            WL_16: n = 6'h10;
            WL_20: n = 6'h14;
            WL_24: n = 6'h18;
            default: n = (fmt == FMT_RJ) ? 6'h18 : 6'h20;
        endcase
        return n;
    endfunction : word_bits

    function automatic logic [9:0] ratio_of(input logic [2:0] rate);
        logic [9:0] r;
        case (rate)
            RATE_384: r = RATIO_384;
            RATE_512: r = RATIO_512;
            RATE_768: r = RATIO_768;
            default: r = RATIO_256; // Unlisted codes run as 256x
        endcase
        return r;
    endfunction : ratio_of

    function automatic logic near_ratio(input logic [9:0] cnt,
                                        input logic [9:0] r);
        return (cnt >= r - RATIO_TOL) && (cnt <= r + RATIO_TOL);
    endfunction : near_ratio

    // Bit i of a word, i counted from the LSB of a wl-bit word
    function automatic logic word_bit(input logic [31:0] w,
                                      input logic [5:0] wl,
                                      input logic [9:0] i);
        logic [5:0] sel;
        sel = 6'h20 - wl + i[5:0];
        return w[sel[4:0]];
    endfunction : word_bit

    // ************************************************
    // Register port
    // ************************************************
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] pwr_ff, nxt_pwr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, lock_ff;
    logic [2:0] det_ff;
    logic [1:0] fmt;
    logic [5:0] wl;
    logic pol, binv, ms, dsp;
    logic [9:0] bpf;

    assign fmt = ctrl_ff[CTRL_FMT_LSB +: 2];
    assign wl = word_bits(fmt, ctrl_ff[CTRL_WL_LSB +: 2]);
    assign pol = ctrl_ff[CTRL_POL_BIT];
    assign binv = ctrl_ff[CTRL_BINV_BIT];
    assign ms = ctrl_ff[CTRL_MS_BIT];
    assign dsp = (fmt == FMT_DSP);
    // Bits per frame in master mode
    assign bpf = dsp ? ratio_of(ctrl_ff[CTRL_RATE_LSB +: 3])
                     : (ratio_of(ctrl_ff[CTRL_RATE_LSB +: 3]) >> 2);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pwr = pwr_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL: nxt_ctrl = reg_wdata_in & CTRL_MASK;
                REG_PWR: nxt_pwr = reg_wdata_in & PWR_MASK;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL: nxt_rdata = ctrl_ff;
                REG_PWR: nxt_rdata = pwr_ff;
                REG_STAT: nxt_rdata = {27'h0, det_ff, lock_ff, err_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff <= CTRL_RESET;
            pwr_ff <= PWR_RESET;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pwr_ff <= nxt_pwr;
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata_out = rdata_ff;

    // ************************************************
    // Power and processing rate controls
    // ************************************************
    logic [4:0] pd_ff, nxt_pd;
    always_comb begin
        nxt_pd[0] = pwr_ff[PWR_INPUT_BIT] | pwr_ff[PWR_GLOBAL_BIT];
        nxt_pd[1] = nxt_pd[0];
        nxt_pd[2] = pwr_ff[PWR_CONV_BIT] | pwr_ff[PWR_GLOBAL_BIT];
        nxt_pd[3] = pwr_ff[PWR_GLOBAL_BIT];
        nxt_pd[4] = ctrl_ff[CTRL_OSR_BIT];
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pd_ff <= 5'h00;
        end else begin
            pd_ff <= nxt_pd;
        end
    end
    assign input_mux_powerdown_out = pd_ff[0];
    assign input_to_midrail_out = pd_ff[1];
    assign converter_powerdown_out = pd_ff[2];
    assign reference_powerdown_out = pd_ff[3];
    assign oversample_sel_out = pd_ff[4];

    // ************************************************
    // Master clock generation
    // ************************************************
    logic [1:0] div_ff, nxt_div;
    logic mbclk_ff, nxt_mbclk;
    logic [9:0] mbit_ff, nxt_mbit;
    logic mfc_ff, nxt_mfc;
    logic m_chg, m_left_lvl;

    always_comb begin
        nxt_div = ms ? div_ff + 2'h1 : 2'h0;
        nxt_mbclk = (ms && div_ff[0]) ? ~mbclk_ff : mbclk_ff;
        if (!ms) begin
            nxt_mbclk = 1'b0;
        end
        // Data change at each falling internal bit clock; every master clock in DSP
        m_chg = ms && (dsp || (div_ff[0] && mbclk_ff));
        m_left_lvl = (fmt == FMT_I2S) ? pol : ~pol;
        nxt_mbit = mbit_ff;
        nxt_mfc = mfc_ff;
        if (m_chg) begin
            nxt_mbit = (mbit_ff >= bpf - 10'h001) ? 10'h000
                                                  : mbit_ff + 10'h001;
            if (dsp) begin
                nxt_mfc = (nxt_mbit == 10'h000);
            end else begin
                nxt_mfc = (nxt_mbit < {1'b0, bpf[9:1]}) ? m_left_lvl
                                                        : ~m_left_lvl;
            end
        end
        if (!ms) begin
            nxt_mbit = 10'h000;
            nxt_mfc = 1'b0;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_ff <= 2'h0;
            mbclk_ff <= 1'b0;
            mbit_ff <= 10'h000;
            mfc_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            mbclk_ff <= nxt_mbclk;
            mbit_ff <= nxt_mbit;
            mfc_ff <= nxt_mfc;
        end
    end

    // Master DSP passes the master clock straight out, phased so that
    // data flops on the rising master edge meet the falling bit edge.
    always_comb begin
        if (ms && dsp) begin
            serial_bit_clock_out = binv ? sys_clk_in : ~sys_clk_in;
        end else begin
            serial_bit_clock_out = mbclk_ff ^ binv;
        end
    end
    assign frame_clock_out = mfc_ff;
    assign serial_bit_clock_oe_n_out = ~ms;
    assign frame_clock_oe_n_out = ~ms;

    // ************************************************
    // Slave pin sampling and ratio detection
    // ************************************************
    logic bclk_d_ff, bclk_d2_ff, fc_d_ff, fcs_ff, fcs_old_ff;
    logic nxt_fcs, nxt_fcs_old, s_rise, s_fall, s_chg, s_smp;
    logic [9:0] mcnt_ff, nxt_mcnt;
    logic nxt_err, nxt_lock, meas;
    logic [2:0] nxt_det;

    always_comb begin
        s_rise = ~bclk_d2_ff & bclk_d_ff;
        s_fall = bclk_d2_ff & ~bclk_d_ff;
        s_chg = ~ms && (binv ? s_rise : s_fall);
        s_smp = ~ms && (binv ? s_fall : s_rise);
        nxt_fcs = s_smp ? fc_d_ff : fcs_ff;
        nxt_fcs_old = s_smp ? fcs_ff : fcs_old_ff;
        meas = s_smp && fc_d_ff && !fcs_ff;
        nxt_mcnt = (mcnt_ff == 10'h3FF) ? mcnt_ff : mcnt_ff + 10'h001;
        nxt_err = err_ff;
        nxt_lock = lock_ff;
        nxt_det = det_ff;
        if (meas) begin
            nxt_mcnt = 10'h001;
            nxt_lock = 1'b1;
            nxt_err = 1'b0;
            if (near_ratio(mcnt_ff, RATIO_256)) begin
                nxt_det = RATE_256;
            end else if (near_ratio(mcnt_ff, RATIO_384)) begin
                nxt_det = RATE_384;
            end else if (near_ratio(mcnt_ff, RATIO_512)) begin
                nxt_det = RATE_512;
            end else if (near_ratio(mcnt_ff, RATIO_768)) begin
                nxt_det = RATE_768;
            end else begin
                nxt_err = 1'b1;
                nxt_lock = 1'b0;
            end
        end
        if (ms) begin
            nxt_err = 1'b0;
            nxt_lock = 1'b0;
            nxt_det = ctrl_ff[CTRL_RATE_LSB +: 3];
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bclk_d_ff <= 1'b0;
            bclk_d2_ff <= 1'b0;
            fc_d_ff <= 1'b0;
            fcs_ff <= 1'b0;
            fcs_old_ff <= 1'b0;
            mcnt_ff <= 10'h000;
            err_ff <= 1'b0;
            lock_ff <= 1'b0;
            det_ff <= 3'h0;
        end else begin
            bclk_d_ff <= serial_bit_clock_in;
            bclk_d2_ff <= bclk_d_ff;
            fc_d_ff <= frame_clock_in;
            fcs_ff <= nxt_fcs;
            fcs_old_ff <= nxt_fcs_old;
            mcnt_ff <= nxt_mcnt;
            err_ff <= nxt_err;
            lock_ff <= nxt_lock;
            det_ff <= nxt_det;
        end
    end

    // ************************************************
    // Serial data engine
    // ************************************************
    logic fc_last_ff, nxt_fc_last, dout_ff, nxt_dout, take_ff, nxt_take;
    logic [9:0] pos_ff, nxt_pos, hlen_ff, nxt_hlen, idx, off;
    logic [31:0] lw_ff, nxt_lw, rw_ff, nxt_rw, w;
    logic chg, fc_now, trans, left, lvl;

    always_comb begin
        chg = ms ? m_chg : s_chg;
        // Slave frame clock changes on the same edge as data, so the
        // level seen at the data edge tells where the word starts.
        fc_now = ms ? nxt_mfc : fc_d_ff;
        trans = chg && (fc_now != fc_last_ff);
        lvl = fc_now ^ pol;
        left = (fmt == FMT_I2S) ? ~lvl : lvl;
        nxt_fc_last = chg ? fc_now : fc_last_ff;
        nxt_pos = pos_ff;
        nxt_hlen = hlen_ff;
        nxt_lw = lw_ff;
        nxt_rw = rw_ff;
        nxt_take = 1'b0;
        nxt_dout = dout_ff;
        idx = 10'h000;
        off = pol ? 10'h000 : 10'h001;
        if (chg) begin
            // DSP counts from the sync rise only; its fall is mid-frame
            if (trans && (!dsp || fc_now)) begin
                nxt_pos = 10'h000;
                nxt_hlen = pos_ff + 10'h001;
            end else if (pos_ff != 10'h3FF) begin
                nxt_pos = pos_ff + 10'h001;
            end
            if (trans && (dsp ? fc_now : left)) begin
                nxt_lw = left_sample_in;
                nxt_rw = right_sample_in;
                nxt_take = 1'b1;
            end
        end
        w = left ? nxt_lw : nxt_rw;
        case (fmt)
            FMT_LJ: begin
                if (nxt_pos < {4'h0, wl}) begin
                    idx = {4'h0, wl} - 10'h001 - nxt_pos;
                    nxt_dout = word_bit(w, wl, idx);
                end else begin
                    nxt_dout = 1'b0;
                end
            end
            FMT_I2S: begin
                // A half of exactly wl bits pushes the LSB past the edge
                if (nxt_pos == 10'h000 && nxt_hlen == {4'h0, wl}) begin
                    nxt_dout = word_bit(left ? rw_ff : lw_ff, wl,
                                        10'h000);
                end else if (nxt_pos != 10'h000
                        && nxt_pos <= {4'h0, wl}) begin
                    idx = {4'h0, wl} - nxt_pos;
                    nxt_dout = word_bit(w, wl, idx);
                end else begin
                    nxt_dout = 1'b0;
                end
            end
            FMT_RJ: begin
                if (nxt_hlen >= {4'h0, wl}
                        && nxt_pos >= nxt_hlen - {4'h0, wl}
                        && nxt_pos < nxt_hlen) begin
                    idx = nxt_hlen - 10'h001 - nxt_pos;
                    nxt_dout = word_bit(w, wl, idx);
                end else begin
                    nxt_dout = 1'b0;
                end
            end
            default: begin
                idx = nxt_pos - off;
                if (nxt_pos < off) begin
                    nxt_dout = 1'b0;
                end else if (idx < {4'h0, wl}) begin
                    nxt_dout = word_bit(nxt_lw, wl,
                                        {4'h0, wl} - 10'h001 - idx);
                end else if (idx < {3'h0, wl, 1'b0}) begin
                    nxt_dout = word_bit(nxt_rw, wl,
                                        {3'h0, wl, 1'b0} - 10'h001 - idx);
                end else begin
                    nxt_dout = 1'b0;
                end
            end
        endcase
        // Ratio error freezes the pin at its last level
        if (!chg || (!ms && err_ff)) begin
            nxt_dout = dout_ff;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fc_last_ff <= 1'b0;
            pos_ff <= 10'h3FF;
            hlen_ff <= 10'h000;
            lw_ff <= 32'h0000_0000;
            rw_ff <= 32'h0000_0000;
            take_ff <= 1'b0;
            dout_ff <= 1'b0;
        end else begin
            fc_last_ff <= nxt_fc_last;
            pos_ff <= nxt_pos;
            hlen_ff <= nxt_hlen;
            lw_ff <= nxt_lw;
            rw_ff <= nxt_rw;
            take_ff <= nxt_take;
            dout_ff <= nxt_dout;
        end
    end
    assign converter_data_out = dout_ff;
    assign sample_take_out = take_ff;

    // ************************************************
    // Checks
    // ************************************************
    default clocking dcb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_global_pd_all: assert property (
        pwr_ff[PWR_GLOBAL_BIT] |=> input_mux_powerdown_out
            && converter_powerdown_out && reference_powerdown_out)
        else $error("global powerdown did not override");
    a_slave_pins_in: assert property (
        !ms |-> frame_clock_oe_n_out && serial_bit_clock_oe_n_out)
        else $error("slave mode drives clock pins");
    a_quarter_bclk: assert property (
        (ms && !dsp && $stable(ctrl_ff))[*4] |->
            mbclk_ff != $past(mbclk_ff, 2) && mbclk_ff == $past(mbclk_ff, 4))
        else $error("master bit clock not a quarter rate");
    a_err_freeze: assert property (
        (!ms && err_ff) |=> $stable(converter_data_out))
        else $error("data moved during ratio error");
    a_bad_ratio: assert property (
        (meas && !ms && mcnt_ff > RATIO_768 + RATIO_TOL) |=> err_ff)
        else $error("ratio error not flagged");
    a_dsp_sync_one: assert property (
        (ms && dsp && $stable(ctrl_ff) && $rose(mfc_ff)) |=> !mfc_ff)
        else $error("master frame sync wider than one bit");
    a_lj_msb_first: assert property (
        (fmt == FMT_LJ && trans && left && (ms || !err_ff))
            |=> converter_data_out == $past(left_sample_in[31]))
        else $error("left justified MSB not at frame edge");
    a_rj_fallback: assert property (
        (fmt == FMT_RJ && ctrl_ff[CTRL_WL_LSB +: 2] == WL_32) |-> wl == 6'h18)
        else $error("right justified 32 bit not reduced");
    a_take_pulse: assert property (
        sample_take_out |=> !sample_take_out)
        else $error("sample take longer than one cycle");
endmodule : adcsp_port
`default_nettype wire

// ==== bench/adcsp_dsp_model.sv ====
// Purpose: Receiving processor that clocks the port in slave mode.
// Assumes: Bit clock is master clock / 8, 32 bit clocks per frame.
// Notes: Both clocks stand still low while run_in is low.
`timescale 1ns/10ps
`default_nettype none
module adcsp_dsp_model (
    input wire logic sys_clk_in,
    input wire logic run_in,
    input wire logic data_in,
    output logic bclk_out,
    output logic frame_out,
    output logic [31:0] frame_word_out
);
    logic [7:0] cnt_ff = 8'h00;
    logic [31:0] sh_ff = 32'h0000_0000;
    // ****************************************
    // Frame of 256 master clocks
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        cnt_ff <= run_in ? cnt_ff + 8'h01 : 8'h00;
        // Taken on rising bit clock, mid bit
        if (run_in && cnt_ff[2:0] == 3'h4) begin
            sh_ff <= {sh_ff[30:0], data_in};
            if (cnt_ff[7:3] == 5'h1F) begin
                frame_word_out <= {sh_ff[30:0], data_in};
            end
        end
    end
    // Frame moves on falling bit clock; halves 16 bits
    assign bclk_out = run_in & cnt_ff[2];
    assign frame_out = run_in & ~cnt_ff[7];
endmodule : adcsp_dsp_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Register and serial link checks of the audio port.
// Assumes: Master clock 40 MHz; far side modelled at 1/8 rate.
// Notes: Master clocks are measured in master clock cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import adcsp_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, rdata, fword, d;
    logic wr_s = 1'b0, rd_s = 1'b0, run = 1'b0, m_bclk, m_frame;
    logic [31:0] lsmp = 32'hA5C3_1234, rsmp = 32'h3C96_5678;
    logic take, fr_o, fr_oe, bk_o, bk_oe, dout, osr, inpd, mid, cvpd, rfpd;
    logic fr_q = 1'b0, bk_q = 1'b0;
    int n_fail = 0, compares = 0, fr_cnt, fr_per, fr_hi, bk_cnt, bk_per;
    int n_take = 0, tk0;
    int rt[4] = '{256, 384, 512, 768};
    logic [3:0] pe[4] = '{4'h3, 4'h4, 4'h7, 4'hF};
    logic [31:0] pw[4] = '{32'h1, 32'h2, 32'h3, 32'h7};
    always #12.5 sys_clk_in = ~sys_clk_in;
    adcsp_port i_adcsp_port (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .left_sample_in(lsmp),
        .right_sample_in(rsmp), .sample_take_out(take),
        .frame_clock_in(m_frame), .frame_clock_out(fr_o),
        .frame_clock_oe_n_out(fr_oe), .serial_bit_clock_in(m_bclk),
        .serial_bit_clock_out(bk_o), .serial_bit_clock_oe_n_out(bk_oe),
        .converter_data_out(dout), .oversample_sel_out(osr),
        .input_mux_powerdown_out(inpd), .input_to_midrail_out(mid),
        .converter_powerdown_out(cvpd), .reference_powerdown_out(rfpd));
    adcsp_dsp_model i_adcsp_dsp_model (.sys_clk_in(sys_clk_in),
        .run_in(run), .data_in(dout), .bclk_out(m_bclk),
        .frame_out(m_frame), .frame_word_out(fword));
    // ****************************************
    // Period meters on the driven clocks
    // ****************************************
    always @(posedge sys_clk_in) begin
        fr_q <= fr_o;
        bk_q <= bk_o;
        fr_cnt <= (fr_o && !fr_q) ? 1 : fr_cnt + 1;
        bk_cnt <= (bk_o && !bk_q) ? 1 : bk_cnt + 1;
        if (fr_o && !fr_q) fr_per <= fr_cnt;
        if (!fr_o && fr_q) fr_hi <= fr_cnt;
        if (bk_o && !bk_q) bk_per <= bk_cnt;
        if (take) n_take <= n_take + 1;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk_in);
        addr <= a;
        wd <= v;
        wr_s <= 1'b1;
        @(posedge sys_clk_in);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk_in);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        rd(REG_CTRL, d);
        chk("ctrl reset", 32'h0000_010A, d);
        rd(REG_PWR, d);
        chk("pwr reset", 32'h0, d);
        rd(4'hF, d);
        chk("unmapped", 32'h0, d);
        chk("slave oe_n", 32'h3, {fr_oe, bk_oe});
        // Partial powerdowns stand before the global one
        for (int i = 0; i < 4; i++) begin
            wr(REG_PWR, pw[i]);
            repeat (2) @(posedge sys_clk_in);
            #1 chk("powerdown", pe[i], {rfpd, cvpd, mid, inpd});
        end
        wr(REG_PWR, 32'h0);
        wr(REG_CTRL, 32'h0000_050A);
        repeat (2) @(posedge sys_clk_in);
        #1 chk("oversample", 32'h1, osr);
        // Left justified master at each listed ratio code, 256x to 768x
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, 32'h41 | ((i + 2) << 7));
            repeat (2304) @(posedge sys_clk_in);
            chk("frame period", rt[i], fr_per);
            chk("frame high", rt[i] / 2, fr_hi);
            chk("bclk period", 32'h4, bk_per);
            chk("master oe_n", 32'h0, {fr_oe, bk_oe});
        end
        wr(REG_CTRL, 32'h143);
        repeat (768) @(posedge sys_clk_in);
        chk("dsp period", 32'd256, fr_per);
        chk("dsp sync", 32'h1, fr_hi);
        @(negedge sys_clk_in);
        #2 chk("dsp bclk lo", 32'h1, bk_o);
        @(posedge sys_clk_in);
        #2 chk("dsp bclk hi", 32'h0, bk_o);
        @(posedge fr_o);
        for (int k = 0; k < 3; k++) begin
            #1 d[2 - k] = dout;
            @(posedge sys_clk_in);
        end
        chk("dsp mode a msb", 32'h2, d[2:0]);
        // Slave, left justified, 16 bit words
        wr(REG_CTRL, 32'h101);
        run <= 1'b1;
        // First period is measured from a saturated count
        repeat (100) @(posedge sys_clk_in);
        rd(REG_STAT, d);
        chk("ratio error", 32'h1, d[1:0]);
        repeat (872) @(posedge sys_clk_in);
        tk0 = n_take;
        repeat (1024) @(posedge sys_clk_in);
        chk("takes", 32'h4, n_take - tk0);
        chk("lj words", 32'hA5C3_3C96, fword);
        rd(REG_STAT, d);
        chk("ratio lock", 32'h2, d[1:0]);
        wr(REG_CTRL, 32'h102);
        repeat (1024) @(posedge sys_clk_in);
        #1 chk("i2s words", 32'h9E4B_52E1, fword);
        wr(REG_CTRL, 32'h100);
        repeat (1024) @(posedge sys_clk_in);
        #1 chk("rj words", 32'hA5C3_3C96, fword);
        wr(REG_CTRL, 32'h113);
        repeat (1024) @(posedge sys_clk_in);
        #1 chk("dsp b words", 32'hA5C3_3C96, fword);
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        n_fail++;
        $display("[FAIL] watchdog expected done seen hang");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
